// *** usb_ep_regs_pkg.sv ***
// Constants, field positions and carrier types for the endpoint status register bank
package usb_ep_regs_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [15:0] IDX_EP8_BC_HIGH = 16'hE69C;
    localparam logic [15:0] IDX_EP8_BC_LOW = 16'hE69D;
    localparam logic [15:0] IDX_EP0_CS = 16'hE6A0;
    localparam logic [15:0] IDX_EP1_OUT_CS = 16'hE6A1;
    localparam logic [15:0] IDX_EP1_IN_CS = 16'hE6A2;
    localparam logic [15:0] IDX_EP2_CS = 16'hE6A3;
    localparam logic [15:0] IDX_EP4_CS = 16'hE6A4;
    localparam logic [15:0] IDX_EP6_CS = 16'hE6A5;
    localparam logic [15:0] IDX_EP8_CS = 16'hE6A6;
    localparam logic [15:0] IDX_EP2_FLAGS = 16'hE6A7;
    localparam logic [15:0] IDX_EP4_FLAGS = 16'hE6A8;
    localparam logic [15:0] IDX_EP6_FLAGS = 16'hE6A9;
    localparam logic [15:0] IDX_EP8_FLAGS = 16'hE6AA;
    localparam logic [15:0] IDX_EP2_TOTAL_HIGH = 16'hE6AB;
    localparam logic [15:0] IDX_EP2_TOTAL_LOW = 16'hE6AC;
    localparam logic [15:0] IDX_EP4_TOTAL_HIGH = 16'hE6AD;
    localparam logic [15:0] IDX_EP4_TOTAL_LOW = 16'hE6AE;
    localparam logic [15:0] IDX_EP6_TOTAL_HIGH = 16'hE6AF;
    localparam logic [15:0] IDX_EP6_TOTAL_LOW = 16'hE6B0;
    localparam logic [15:0] IDX_EP8_TOTAL_HIGH = 16'hE6B1;
    localparam logic [15:0] IDX_EP8_TOTAL_LOW = 16'hE6B2;
    localparam logic [15:0] IDX_SETUP_PTR_HIGH = 16'hE6B3;
    localparam logic [15:0] IDX_SETUP_PTR_LOW = 16'hE6B4;
    localparam logic [15:0] IDX_SETUP_PTR_CTRL = 16'hE6B5;
    localparam logic [15:0] IDX_SETUP_BUF_FIRST = 16'hE6B8;
    localparam logic [15:0] IDX_SETUP_BUF_LAST = 16'hE6BF;
    localparam logic [15:0] IDX_WAVE_SELECT = 16'hE6C0;
    localparam logic [15:0] IDX_WAVE_IDLE_CS = 16'hE6C1;
    localparam logic [15:0] IDX_WAVE_IDLE_LEVELS = 16'hE6C2;
    localparam logic [15:0] IDX_WAVE_DRIVE_TYPE = 16'hE6C3;
    localparam logic [15:0] IDX_WAVE_ADDR_HIGH = 16'hE6C4;
    localparam logic [15:0] IDX_WAVE_ADDR_LOW = 16'hE6C5;
    localparam logic [15:0] IDX_FLOW_STATE = 16'hE6C6;
    localparam logic [15:0] IDX_FLOW_LOGIC = 16'hE6C7;
    localparam logic [15:0] IDX_FLOW_FALSE_LEVELS = 16'hE6C8;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hE6F0;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hE6F1;

    // Reset values
    localparam logic [7:0] RST_EP0_CS = 8'h80;
    localparam logic [7:0] RST_SETUP_PTR_CTRL = 8'h01;
    localparam logic [7:0] RST_WAVE_SELECT = 8'hE4;
    localparam logic [7:0] RST_WAVE_IDLE_LEVELS = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Field positions and masks
    localparam int STALL_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int HOLD_BIT = 7;
    localparam int IDLE_DRIVE_BIT = 0;
    localparam int DONE_BIT = 7;
    localparam logic [7:0] DRIVE_TYPE_MASK = 8'hBF;
    localparam logic [7:0] FLOW_STATE_MASK = 8'h87;
    localparam logic [7:0] SETUP_LOW_MASK = 8'hFE;

    // Stall vector positions
    localparam int ST_EP0 = 0;
    localparam int ST_EP1_OUT = 1;
    localparam int ST_EP1_IN = 2;
    localparam int ST_EP2 = 3;
    localparam int ST_EP4 = 4;
    localparam int ST_EP6 = 5;
    localparam int ST_EP8 = 6;
    localparam int NUM_STALL = 7;

    // Interrupt status bits
    localparam int IRQ_SETUP = 0;
    localparam int IRQ_WAVE_DONE = 1;
    localparam int IRQ_FIFO_FULL_LSB = 2;
    localparam int IRQ_W = 6;

    // Status driven by the endpoint logic; index 0..3 of vectors is ep2, ep4, ep6, ep8
    typedef struct packed {
        logic ep0_busy;
        logic ep1_out_busy;
        logic ep1_in_busy;
        logic [2:0] ep2_packet_count;
        logic [1:0] ep4_packet_count;
        logic [2:0] ep6_packet_count;
        logic [1:0] ep8_packet_count;
        logic [3:0] ep_full;
        logic [3:0] ep_empty;
        logic [3:0] programmable_flag;
        logic [3:0] empty_flag;
        logic [3:0] full_flag;
        logic [12:0] ep2_total;
        logic [10:0] ep4_total;
        logic [11:0] ep6_total;
        logic [10:0] ep8_total;
    } ep_status_t;

    // Controls driven out to the endpoint logic and the waveform engine
    typedef struct packed {
        logic [NUM_STALL-1:0] stall;
        logic ep0_hold;
        logic [9:0] ep8_byte_count_bits;
        logic ep8_commit;
        logic [15:0] setup_pointer;
        logic setup_pointer_auto;
        logic [7:0] wave_select;
        logic idle_drive_select;
        logic [7:0] idle_levels;
        logic [7:0] drive_type;
        logic [8:0] wave_address;
        logic [7:0] flow_state;
        logic [7:0] flow_logic;
        logic [7:0] flow_false_levels;
    } ctrl_out_t;

endpackage

// *** usb_endpoint_status_register_bank.sv ***
// APB register bank for endpoint status, setup data and waveform configuration
`timescale 1ns/1ps
// Overview of operation
// - Endpoint 8 byte count is 10 bits; low byte top bit doubles as skip control.
// - Endpoint 0 status shows busy bit 1, stall bit 0, resets to 0x80.
// - Endpoint 1 IN and OUT status show busy and stall, others zero, reset zero.
// - Endpoints 2 and 6 show 3-bit packet count, full, empty, stall.
// - Endpoints 4 and 8 show 2-bit packet count, bits 7:6 zero.
// - Bulk endpoint status writes change only the stall bit.
// - FIFO flag registers read-only: programmable, empty, full in bits 2..0.
// - Endpoint 6 and 8 FIFO flags reset showing programmable and empty.
// - FIFO total byte counts read-only, widths 13, 11, 12, 11 bits.
// - Setup pointer high byte is read-write address bits 15:8.
// - Setup pointer bit 0 always reads zero; bits 7:1 writable.
// - Idle control-line levels in bits 5:0, register resets to 0xFF; here all 8 bits are written and read back.
module usb_endpoint_status_register_bank #(
    parameter int ADDR_W = 18
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire usb_ep_regs_pkg::ep_status_t ep_status,
    input wire logic [63:0] setup_packet,
    input wire logic setup_received,
    input wire logic wave_done,
    output usb_ep_regs_pkg::ctrl_out_t ctrl,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        usb_ep_regs_pkg::ctrl_out_t ctl;
        logic [usb_ep_regs_pkg::IRQ_W-1:0] irq_status;
        logic [usb_ep_regs_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic slverr;
        logic prev_done;
        logic [3:0] prev_full;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Read value plus hit flag for one register index
    typedef struct packed {
        logic hit;
        logic [7:0] value;
    } read_t;

    logic [15:0] index;
    logic setup_phase;
    logic access_phase;
    logic [usb_ep_regs_pkg::IRQ_W-1:0] events;

    // Bus decode; registers sit one per aligned word
    assign index = paddr[17:2];
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    ////////////////////////////////////////////////////////////////////////////
    // Read decode

    // Bulk endpoint status byte; narrow counts leave the upper bits zero
    function automatic logic [7:0] bulk_status(input logic [2:0] count, input logic full,
                                               input logic empty, input logic stall);
        bulk_status = {1'b0, count, full, empty, 1'b0, stall};
    endfunction

    function automatic read_t read_reg(input logic [15:0] idx, input state_t s,
                                       input usb_ep_regs_pkg::ep_status_t st,
                                       input logic [63:0] pkt, input logic done);
        read_t r;
        logic [2:0] slot;
        r.hit = 1'b1;
        r.value = 8'h00;
        slot = idx[2:0];
        case (idx)
            usb_ep_regs_pkg::IDX_EP8_BC_HIGH: begin
                r.value = {6'h00, s.ctl.ep8_byte_count_bits[9:8]};
            end
            usb_ep_regs_pkg::IDX_EP8_BC_LOW: begin
                r.value = s.ctl.ep8_byte_count_bits[7:0];
            end
            usb_ep_regs_pkg::IDX_EP0_CS: begin
                r.value = {s.ctl.ep0_hold, 5'h00, st.ep0_busy, s.ctl.stall[usb_ep_regs_pkg::ST_EP0]};
            end
            usb_ep_regs_pkg::IDX_EP1_OUT_CS: begin
                r.value = {6'h00, st.ep1_out_busy, s.ctl.stall[usb_ep_regs_pkg::ST_EP1_OUT]};
            end
            usb_ep_regs_pkg::IDX_EP1_IN_CS: begin
                r.value = {6'h00, st.ep1_in_busy, s.ctl.stall[usb_ep_regs_pkg::ST_EP1_IN]};
            end
            usb_ep_regs_pkg::IDX_EP2_CS: begin
                r.value = bulk_status(st.ep2_packet_count, st.ep_full[0], st.ep_empty[0],
                                      s.ctl.stall[usb_ep_regs_pkg::ST_EP2]);
            end
            usb_ep_regs_pkg::IDX_EP4_CS: begin
                r.value = bulk_status({1'b0, st.ep4_packet_count}, st.ep_full[1], st.ep_empty[1],
                                      s.ctl.stall[usb_ep_regs_pkg::ST_EP4]);
            end
            usb_ep_regs_pkg::IDX_EP6_CS: begin
                r.value = bulk_status(st.ep6_packet_count, st.ep_full[2], st.ep_empty[2],
                                      s.ctl.stall[usb_ep_regs_pkg::ST_EP6]);
            end
            usb_ep_regs_pkg::IDX_EP8_CS: begin
                r.value = bulk_status({1'b0, st.ep8_packet_count}, st.ep_full[3], st.ep_empty[3],
                                      s.ctl.stall[usb_ep_regs_pkg::ST_EP8]);
            end
            usb_ep_regs_pkg::IDX_EP2_FLAGS, usb_ep_regs_pkg::IDX_EP4_FLAGS,
            usb_ep_regs_pkg::IDX_EP6_FLAGS, usb_ep_regs_pkg::IDX_EP8_FLAGS: begin
                // Flag slot is the index offset from the ep2 flags register
                r.value = {5'h00, st.programmable_flag[idx[1:0] + 2'h1],
                           st.empty_flag[idx[1:0] + 2'h1], st.full_flag[idx[1:0] + 2'h1]};
            end
            usb_ep_regs_pkg::IDX_EP2_TOTAL_HIGH: r.value = {3'h0, st.ep2_total[12:8]};
            usb_ep_regs_pkg::IDX_EP2_TOTAL_LOW: r.value = st.ep2_total[7:0];
            usb_ep_regs_pkg::IDX_EP4_TOTAL_HIGH: r.value = {5'h00, st.ep4_total[10:8]};
            usb_ep_regs_pkg::IDX_EP4_TOTAL_LOW: r.value = st.ep4_total[7:0];
            usb_ep_regs_pkg::IDX_EP6_TOTAL_HIGH: r.value = {4'h0, st.ep6_total[11:8]};
            usb_ep_regs_pkg::IDX_EP6_TOTAL_LOW: r.value = st.ep6_total[7:0];
            usb_ep_regs_pkg::IDX_EP8_TOTAL_HIGH: r.value = {5'h00, st.ep8_total[10:8]};
            usb_ep_regs_pkg::IDX_EP8_TOTAL_LOW: r.value = st.ep8_total[7:0];
            usb_ep_regs_pkg::IDX_SETUP_PTR_HIGH: r.value = s.ctl.setup_pointer[15:8];
            usb_ep_regs_pkg::IDX_SETUP_PTR_LOW: begin
                r.value = s.ctl.setup_pointer[7:0] & usb_ep_regs_pkg::SETUP_LOW_MASK;
            end
            usb_ep_regs_pkg::IDX_SETUP_PTR_CTRL: r.value = {7'h00, s.ctl.setup_pointer_auto};
            usb_ep_regs_pkg::IDX_WAVE_SELECT: r.value = s.ctl.wave_select;
            usb_ep_regs_pkg::IDX_WAVE_IDLE_CS: r.value = {done, 6'h00, s.ctl.idle_drive_select};
            usb_ep_regs_pkg::IDX_WAVE_IDLE_LEVELS: r.value = s.ctl.idle_levels;
            usb_ep_regs_pkg::IDX_WAVE_DRIVE_TYPE: r.value = s.ctl.drive_type;
            usb_ep_regs_pkg::IDX_WAVE_ADDR_HIGH: r.value = {7'h00, s.ctl.wave_address[8]};
            usb_ep_regs_pkg::IDX_WAVE_ADDR_LOW: r.value = s.ctl.wave_address[7:0];
            usb_ep_regs_pkg::IDX_FLOW_STATE: r.value = s.ctl.flow_state;
            usb_ep_regs_pkg::IDX_FLOW_LOGIC: r.value = s.ctl.flow_logic;
            usb_ep_regs_pkg::IDX_FLOW_FALSE_LEVELS: r.value = s.ctl.flow_false_levels;
            usb_ep_regs_pkg::IDX_IRQ_STATUS: r.value = {2'h0, s.irq_status};
            usb_ep_regs_pkg::IDX_IRQ_MASK: r.value = {2'h0, s.irq_mask};
            default: begin
                // Setup buffer: byte n of the packet sits at the nth index of the block
                if (idx >= usb_ep_regs_pkg::IDX_SETUP_BUF_FIRST && idx <= usb_ep_regs_pkg::IDX_SETUP_BUF_LAST) begin
                    r.value = pkt[{slot, 3'h0} +: 8];
                end else begin
                    r.hit = 1'b0;
                end
            end
        endcase
        read_reg = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Events: setup arrival, rising edge of waveform done, rising FIFO full flags
    assign events = {ep_status.full_flag & ~state_reg.prev_full,
                     wave_done & ~state_reg.prev_done,
                     setup_received};

    always_comb begin
        read_t rd;
        logic wr;
        logic [7:0] wd;
        state_next = state_reg;
        rd = read_reg(index, state_reg, ep_status, setup_packet, wave_done);
        wr = access_phase && pwrite && pstrb[0];
        wd = pwdata[7:0];
        state_next.ctl.ep8_commit = 1'b0;
        state_next.prev_done = wave_done;
        state_next.prev_full = ep_status.full_flag;

        // Read data and error are captured in the setup cycle so they leave flip-flops
        if (setup_phase) begin
            state_next.rdata = {24'h000000, rd.value};
            state_next.slverr = !rd.hit;
        end

        // A read of the status register clears the bits it returned
        if (access_phase && !pwrite && index == usb_ep_regs_pkg::IDX_IRQ_STATUS) begin
            state_next.irq_status = state_reg.irq_status & ~state_reg.rdata[usb_ep_regs_pkg::IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle
        state_next.irq_status = state_next.irq_status | events;

        if (wr) begin
            case (index)
                usb_ep_regs_pkg::IDX_EP8_BC_HIGH: state_next.ctl.ep8_byte_count_bits[9:8] = wd[1:0];
                usb_ep_regs_pkg::IDX_EP8_BC_LOW: begin
                    // Bit 7 is both count bit 7 and the skip request for the commit
                    state_next.ctl.ep8_byte_count_bits[7:0] = wd;
                    state_next.ctl.ep8_commit = 1'b1;
                end
                usb_ep_regs_pkg::IDX_EP0_CS: begin
                    state_next.ctl.ep0_hold = wd[usb_ep_regs_pkg::HOLD_BIT];
                    state_next.ctl.stall[usb_ep_regs_pkg::ST_EP0] = wd[usb_ep_regs_pkg::STALL_BIT];
                end
                usb_ep_regs_pkg::IDX_EP1_OUT_CS: begin
                    state_next.ctl.stall[usb_ep_regs_pkg::ST_EP1_OUT] = wd[usb_ep_regs_pkg::STALL_BIT];
                end
                usb_ep_regs_pkg::IDX_EP1_IN_CS: begin
                    state_next.ctl.stall[usb_ep_regs_pkg::ST_EP1_IN] = wd[usb_ep_regs_pkg::STALL_BIT];
                end
                usb_ep_regs_pkg::IDX_EP2_CS, usb_ep_regs_pkg::IDX_EP4_CS,
                usb_ep_regs_pkg::IDX_EP6_CS, usb_ep_regs_pkg::IDX_EP8_CS: begin
                    // Only stall is writable; counts and flags belong to the endpoint logic
                    state_next.ctl.stall[index[2:0]] = wd[usb_ep_regs_pkg::STALL_BIT];
                end
                usb_ep_regs_pkg::IDX_SETUP_PTR_HIGH: state_next.ctl.setup_pointer[15:8] = wd;
                usb_ep_regs_pkg::IDX_SETUP_PTR_LOW: begin
                    state_next.ctl.setup_pointer[7:0] = wd & usb_ep_regs_pkg::SETUP_LOW_MASK;
                end
                usb_ep_regs_pkg::IDX_SETUP_PTR_CTRL: state_next.ctl.setup_pointer_auto = wd[0];
                usb_ep_regs_pkg::IDX_WAVE_SELECT: state_next.ctl.wave_select = wd;
                usb_ep_regs_pkg::IDX_WAVE_IDLE_CS: begin
                    state_next.ctl.idle_drive_select = wd[usb_ep_regs_pkg::IDLE_DRIVE_BIT];
                end
                usb_ep_regs_pkg::IDX_WAVE_IDLE_LEVELS: state_next.ctl.idle_levels = wd;
                usb_ep_regs_pkg::IDX_WAVE_DRIVE_TYPE: begin
                    state_next.ctl.drive_type = wd & usb_ep_regs_pkg::DRIVE_TYPE_MASK;
                end
                usb_ep_regs_pkg::IDX_WAVE_ADDR_HIGH: state_next.ctl.wave_address[8] = wd[0];
                usb_ep_regs_pkg::IDX_WAVE_ADDR_LOW: state_next.ctl.wave_address[7:0] = wd;
                usb_ep_regs_pkg::IDX_FLOW_STATE: state_next.ctl.flow_state = wd & usb_ep_regs_pkg::FLOW_STATE_MASK;
                usb_ep_regs_pkg::IDX_FLOW_LOGIC: state_next.ctl.flow_logic = wd;
                usb_ep_regs_pkg::IDX_FLOW_FALSE_LEVELS: state_next.ctl.flow_false_levels = wd;
                usb_ep_regs_pkg::IDX_IRQ_MASK: state_next.irq_mask = wd[usb_ep_regs_pkg::IRQ_W-1:0];
                default: begin
                    // Read-only and unmapped indices ignore writes
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Reset image; setup pointer is undefined in the part, forced to zero here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.ctl.ep0_hold <= usb_ep_regs_pkg::RST_EP0_CS[usb_ep_regs_pkg::HOLD_BIT];
            state_reg.ctl.setup_pointer_auto <= usb_ep_regs_pkg::RST_SETUP_PTR_CTRL[0];
            state_reg.ctl.wave_select <= usb_ep_regs_pkg::RST_WAVE_SELECT;
            state_reg.ctl.idle_levels <= usb_ep_regs_pkg::RST_WAVE_IDLE_LEVELS;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero-wait slave: data was latched in setup, so access completes at once
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = access_phase && state_reg.slverr;
    assign ctrl = state_reg.ctl;
    assign irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule // usb_endpoint_status_register_bank

// *** ep_regs_checker.sv ***
// Port-level assertions for the endpoint status register bank
`timescale 1ns/1ps
module ep_regs_checker #(
    parameter int ADDR_W = 18
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire usb_ep_regs_pkg::ep_status_t ep_status,
    input wire logic [63:0] setup_packet,
    input wire usb_ep_regs_pkg::ctrl_out_t ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // Access phases; read data was captured at the setup edge, hence $past
    sequence wr_acc(logic [15:0] idx);
        psel && penable && pwrite && pstrb[0] && paddr[ADDR_W-1:2] == idx;
    endsequence
    sequence rd_acc(logic [15:0] idx);
        psel && penable && !pwrite && paddr[ADDR_W-1:2] == idx;
    endsequence
    // Reset values, write effects and read capture
    reset_ctrl_a:
        assert property ($rose(nrst) |-> ctrl.ep0_hold && ctrl.stall == '0 && ctrl.wave_select == 8'hE4
            && ctrl.idle_levels == 8'hFF) else $error("control reset values wrong");
    commit_pulse_a:
        assert property (wr_acc(usb_ep_regs_pkg::IDX_EP8_BC_LOW) |=> ctrl.ep8_commit
            && ctrl.ep8_byte_count_bits[7:0] == $past(pwdata[7:0]) ##1 !ctrl.ep8_commit) else $error("commit wrong");
    stall_write_a:
        assert property (wr_acc(usb_ep_regs_pkg::IDX_EP2_CS) |=> ctrl.stall[usb_ep_regs_pkg::ST_EP2]
            == $past(pwdata[0])) else $error("bulk stall write lost");
    ep4_status_a:
        assert property (rd_acc(usb_ep_regs_pkg::IDX_EP4_CS) |-> prdata[7:0] == {2'b00,
            $past(ep_status.ep4_packet_count), $past(ep_status.ep_full[1]), $past(ep_status.ep_empty[1]),
            1'b0, ctrl.stall[usb_ep_regs_pkg::ST_EP4]}) else $error("endpoint 4 status wrong");
    flags_read_a:
        assert property (rd_acc(usb_ep_regs_pkg::IDX_EP6_FLAGS) |-> prdata[7:0] == {5'b00000,
            $past(ep_status.programmable_flag[2]), $past(ep_status.empty_flag[2]), $past(ep_status.full_flag[2])})
            else $error("fifo flags wrong");
    total_high_a:
        assert property (rd_acc(usb_ep_regs_pkg::IDX_EP2_TOTAL_HIGH) |-> prdata[7:0] == {3'b000,
            $past(ep_status.ep2_total[12:8])}) else $error("total byte count wrong");
    ptr_even_a:
        assert property (wr_acc(usb_ep_regs_pkg::IDX_SETUP_PTR_LOW) |=> ctrl.setup_pointer[7:0]
            == ($past(pwdata[7:0]) & 8'hFE)) else $error("setup pointer low wrong");
    setup_buf_a:
        assert property (psel && penable && !pwrite && paddr[ADDR_W-1:5] == 13'h1CD7 |-> prdata[7:0]
            == 8'($past(setup_packet) >> {paddr[4:2], 3'b000})) else $error("setup buffer byte wrong");
endmodule // ep_regs_checker
// Attach to every instance of the bank
bind usb_endpoint_status_register_bank ep_regs_checker #(.ADDR_W(ADDR_W)) checker_u (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .ep_status(ep_status), .setup_packet(setup_packet), .ctrl(ctrl));

// *** tb.sv ***
// Self-checking bench for the endpoint status register bank
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, irq, err;
    usb_ep_regs_pkg::ep_status_t ep_status = '0;
    usb_ep_regs_pkg::ctrl_out_t ctrl;
    logic [63:0] setup_packet = '0;
    logic setup_received = 1'b0, wave_done = 1'b0;
    int mismatches = 0, compares = 0, seed = 32'h9EB5;
    logic [6:0] stall_m = '0;
    logic [7:0] rd;
    // Reset view: word index, then expected byte
    logic [23:0] rst_tab [$] = {24'hE6A080, 24'hE6A100, 24'hE6A200, 24'hE6A328, 24'hE6A428, 24'hE6A504,
        24'hE6A604, 24'hE6A702, 24'hE6A802, 24'hE6A906, 24'hE6AA06, 24'hE6AB00, 24'hE6B200, 24'hE6B501,
        24'hE6C0E4, 24'hE6C2FF, 24'hE6C300, 24'hE6C400, 24'hE6C500, 24'hE6C600, 24'hE6C700, 24'hE6C800};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    usb_endpoint_status_register_bank #(.ADDR_W(18)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ep_status(ep_status), .setup_packet(setup_packet),
        .setup_received(setup_received), .wave_done(wave_done), .ctrl(ctrl), .irq(irq));
    ////////////////////////////////////////
    // Counts and verdict; the only exit of the run
    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Case equality, so an unknown never passes
    task automatic check_eq(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd = 8'h00,
        input logic [3:0] be = 4'hF);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb <= be;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (n = 0; pready !== 1'b1; n++) begin
            if (n == 20) begin
                mismatches++;
                end_sim();
            end
            @(posedge clk);
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Expected read byte from the status inputs and the stall model
    function automatic logic [7:0] expect_rd(input logic [15:0] idx);
        usb_ep_regs_pkg::ep_status_t s;
        logic [15:0] tot [4];
        int f;
        int t;
        s = ep_status;
        f = idx - 16'hE6A7;
        t = idx - 16'hE6AB;
        tot = '{16'(s.ep2_total), 16'(s.ep4_total), 16'(s.ep6_total), 16'(s.ep8_total)};
        case (idx) inside
            16'hE6A0: return {6'h20, s.ep0_busy, stall_m[0]};
            16'hE6A1: return {6'h00, s.ep1_out_busy, stall_m[1]};
            16'hE6A2: return {6'h00, s.ep1_in_busy, stall_m[2]};
            16'hE6A3: return {1'b0, s.ep2_packet_count, s.ep_full[0], s.ep_empty[0], 1'b0, stall_m[3]};
            16'hE6A4: return {2'b00, s.ep4_packet_count, s.ep_full[1], s.ep_empty[1], 1'b0, stall_m[4]};
            16'hE6A5: return {1'b0, s.ep6_packet_count, s.ep_full[2], s.ep_empty[2], 1'b0, stall_m[5]};
            16'hE6A6: return {2'b00, s.ep8_packet_count, s.ep_full[3], s.ep_empty[3], 1'b0, stall_m[6]};
            [16'hE6A7:16'hE6AA]: return {5'h00, s.programmable_flag[f], s.empty_flag[f], s.full_flag[f]};
            [16'hE6AB:16'hE6B2]: return t[0] ? tot[t / 2][7:0] : tot[t / 2][15:8];
            [16'hE6B8:16'hE6BF]: return setup_packet[8 * (idx - 16'hE6B8) +: 8];
            default: return 8'h00;
        endcase
    endfunction
    // Main sequence; after the blocking status setup at time zero, inputs change only by non-blocking assignment after an edge
    initial begin
        logic [15:0] idx;
        logic [7:0] w, h;
        logic [3:0] be;
        int n;
        ep_status.ep2_packet_count = 3'h2;
        ep_status.ep4_packet_count = 2'h2;
        ep_status.ep_full = 4'h3;
        ep_status.ep_empty = 4'hC;
        ep_status.programmable_flag = 4'hC;
        ep_status.empty_flag = 4'hF;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (rst_tab[i]) begin
            apb(1'b0, rst_tab[i][23:8]);
            check_eq(rd, rst_tab[i][7:0]);
        end
        // Byte count split, skip bit set; unused high bits read zero
        apb(1'b1, 16'hE69C, 8'hFF);
        apb(1'b1, 16'hE69D, 8'h85);
        check_eq(ctrl.ep8_byte_count_bits, 10'h385);
        apb(1'b0, 16'hE69C);
        check_eq(rd, 8'h03);
        // Setup pointer with an odd low byte written
        w = 8'($random(seed)) | 8'h01;
        h = 8'($random(seed));
        apb(1'b1, 16'hE6B3, h);
        apb(1'b1, 16'hE6B4, w);
        apb(1'b0, 16'hE6B4);
        check_eq(rd, w & 8'hFE);
        apb(1'b0, 16'hE6B3);
        check_eq(rd, h);
        // Waveform configuration
        apb(1'b1, 16'hE6C0, w);
        check_eq(ctrl.wave_select, w);
        apb(1'b1, 16'hE6C2, h);
        apb(1'b0, 16'hE6C2);
        check_eq(rd, h);
        apb(1'b1, 16'hE6C4, 8'hFF);
        apb(1'b1, 16'hE6C5, w);
        check_eq(ctrl.wave_address, {1'b1, w});
        apb(1'b1, 16'hE6C3, 8'hFF);
        apb(1'b0, 16'hE6C3);
        check_eq(rd, 8'hBF);
        // Unmapped word: error, write dropped, reads zero
        apb(1'b1, 16'hE6B6, 8'hFF);
        check_eq(err, 1'b1);
        apb(1'b0, 16'hE6B6);
        check_eq({err, rd}, 9'h100);
        // Random status, random stall writes with random strobes, random reads
        repeat (80) begin
            ep_status <= 80'({$random(seed), $random(seed), $random(seed)});
            setup_packet <= {$random(seed), $random(seed)};
            n = $unsigned($random(seed)) % 7;
            w = 8'($random(seed));
            be = 4'($random(seed));
            apb(1'b1, 16'hE6A0 + 16'(n), (n == 0) ? (w | 8'h80) : w, be);
            if (be[0]) begin
                stall_m[n] = w[0];
            end
            n = $unsigned($random(seed)) % 27;
            idx = 16'hE6A0 + 16'(n) + ((n > 18) ? 16'h0005 : 16'h0000);
            apb(1'b0, idx);
            check_eq(rd, expect_rd(idx));
        end
        // Interrupt: masked setup event, unmasked wave-done event with masked full flag event, read-to-clear
        ep_status.full_flag <= 4'h0;
        repeat (2) @(posedge clk);
        apb(1'b0, 16'hE6F0);
        apb(1'b1, 16'hE6F1, 8'h02);
        setup_received <= 1'b1;
        @(posedge clk);
        setup_received <= 1'b0;
        repeat (3) @(posedge clk);
        check_eq(irq, 1'b0);
        wave_done <= 1'b1;
        ep_status.full_flag <= 4'h1;
        repeat (3) @(posedge clk);
        check_eq(irq, 1'b1);
        apb(1'b0, 16'hE6F0);
        check_eq(rd, 8'h07);
        repeat (2) @(posedge clk);
        check_eq(irq, 1'b0);
        end_sim();
    end
endmodule // tb
